// file: shared/fpc_pkg.sv
// constants, command codes and timing counts shared by the flash host files
package fpc_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int SYNC_STAGES = 2;

  // bus timing in ns; all are least times and round up
  localparam int T_SETUP_NS = 25;
  localparam int T_GLITCH_NS = 5;
  localparam int T_WRITE_PULSE_NS = 50;
  localparam int T_ACCESS_NS = 90;
  localparam int T_HOLD_NS = 25;
  localparam int T_RESET_PULSE_NS = 500;
  localparam int T_RESET_RECOVER_NS = 50;
  localparam int T_HV_SETTLE_NS = 4000;

  localparam int SETUP_CYC = (T_SETUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int WRITE_CYC = (T_WRITE_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int GLITCH_CYC = (T_GLITCH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  // read strobe also covers the two synchroniser stages on the data pins
  localparam int READ_CYC = (T_ACCESS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS + SYNC_STAGES;
  localparam int HOLD_CYC = (T_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RESET_PULSE_CYC = (T_RESET_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RESET_RECOVER_CYC =
    (T_RESET_RECOVER_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int HV_SETTLE_CYC = (T_HV_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // address field and status bit positions
  localparam int BIT_A0 = 0;
  localparam int BIT_A1 = 1;
  localparam int BIT_A6 = 6;
  localparam int BIT_A9 = 9;
  localparam int FIRST_SECTOR_LSB = 15;
  localparam int GROUP_LSB = 16;
  localparam int PROTECTED_BIT = 0;
  localparam int LOCK_INDICATOR_BIT = 7;

  // unlock and command words
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_1 = 22'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_2 = 22'h0002AA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA_1 = 16'h00AA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA_2 = 16'h0055;
  localparam logic [DATA_W-1:0] SEQ_ENTER_SECURED = 16'h0088;
  localparam logic [DATA_W-1:0] SEQ_AUTOSELECT = 16'h0090;
  localparam logic [DATA_W-1:0] SEQ_PROGRAM = 16'h00A0;
  localparam logic [DATA_W-1:0] SEQ_EXIT_SECURED = 16'h0000;

  typedef enum logic [3:0] {
    CMD_READ = 4'h0,
    CMD_PROGRAM = 4'h1,
    CMD_WRITE_RAW = 4'h2,
    CMD_ENTER_SECURED = 4'h3,
    CMD_EXIT_SECURED = 4'h4,
    CMD_READ_MFR_ID = 4'h5,
    CMD_READ_DEV_ID = 4'h6,
    CMD_VERIFY_PROTECT = 4'h7,
    CMD_HW_RESET = 4'h8,
    CMD_TEMP_UNPROTECT_ON = 4'h9,
    CMD_TEMP_UNPROTECT_OFF = 4'hA
  } fpc_cmd_t;
endpackage

// file: hdl/fpc_bus_cycle.sv
// one timed read or write cycle on the asynchronous flash pins
module fpc_bus_cycle #(
  parameter int SETUP_CYC = fpc_pkg::SETUP_CYC,
  parameter int WRITE_CYC = fpc_pkg::WRITE_CYC,
  parameter int READ_CYC = fpc_pkg::READ_CYC,
  parameter int HOLD_CYC = fpc_pkg::HOLD_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // cycle request
  input wire logic start,
  input wire logic abort,
  input wire logic in_write,
  input wire logic [fpc_pkg::ADDR_W-1:0] in_addr,
  input wire logic [fpc_pkg::DATA_W-1:0] in_data,
  output logic done,
  output logic [fpc_pkg::DATA_W-1:0] rdata,
  // flash pins
  output logic [fpc_pkg::ADDR_W-1:0] addr,
  input wire logic [fpc_pkg::DATA_W-1:0] dq_in,
  output logic [fpc_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic ce_n,
  output logic oe_n,
  output logic we_n
);
  localparam int CNT_W = 4;
  if (SETUP_CYC < 1 || WRITE_CYC <= fpc_pkg::GLITCH_CYC || READ_CYC < 1 || HOLD_CYC < 1 ||
      SETUP_CYC > 15 || WRITE_CYC > 15 || READ_CYC > 15 || HOLD_CYC > 15) begin : g_chk
    $error("fpc_bus_cycle: phase counts out of range");
  end

  typedef enum logic [3:0] {
    CY_IDLE = 4'h1, CY_SETUP = 4'h2, CY_STROBE = 4'h4, CY_HOLD = 4'h8
  } fpc_cy_state_t;

  fpc_cy_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic wr, next_wr;
  logic next_done, next_dq_oe, next_ce_n, next_oe_n, next_we_n;
  logic [fpc_pkg::ADDR_W-1:0] next_addr;
  logic [fpc_pkg::DATA_W-1:0] next_dq_out, next_rdata, dq_meta, dq_sync;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wr = wr;
    next_addr = addr;
    next_dq_out = dq_out;
    next_dq_oe = dq_oe;
    next_ce_n = ce_n;
    next_oe_n = oe_n;
    next_we_n = we_n;
    next_rdata = rdata;
    next_done = 1'b0;
    case (state)
      CY_IDLE: begin
        // address is set here and held until the next start
        if (start) begin
          next_addr = in_addr;
          next_dq_out = in_data;
          next_dq_oe = in_write;
          next_wr = in_write;
          next_cnt = CNT_W'(SETUP_CYC - 1);
          next_state = CY_SETUP;
        end
      end
      CY_SETUP: begin
        if (cnt == '0) begin
          next_ce_n = 1'b0;
          next_we_n = ~wr;
          next_oe_n = wr; // output gate stays high for writes
          next_cnt = wr ? CNT_W'(WRITE_CYC - 1) : CNT_W'(READ_CYC - 1);
          next_state = CY_STROBE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      CY_STROBE: begin
        if (cnt == '0) begin
          if (!wr) begin
            next_rdata = dq_sync;
          end
          next_ce_n = 1'b1;
          next_oe_n = 1'b1;
          next_we_n = 1'b1;
          next_cnt = CNT_W'(HOLD_CYC - 1);
          next_state = CY_HOLD;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      CY_HOLD: begin
        // data stays driven past the rising strobe edge
        if (cnt == '0) begin
          next_dq_oe = 1'b0;
          next_done = 1'b1;
          next_state = CY_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: next_state = CY_IDLE;
    endcase
    if (abort) begin
      next_state = CY_IDLE;
      next_ce_n = 1'b1;
      next_oe_n = 1'b1;
      next_we_n = 1'b1;
      next_dq_oe = 1'b0;
      next_done = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= CY_IDLE;
      cnt <= '0;
      wr <= 1'b0;
      addr <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      rdata <= '0;
      done <= 1'b0;
      dq_meta <= '0;
      dq_sync <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wr <= next_wr;
      addr <= next_addr;
      dq_out <= next_dq_out;
      dq_oe <= next_dq_oe;
      ce_n <= next_ce_n;
      oe_n <= next_oe_n;
      we_n <= next_we_n;
      rdata <= next_rdata;
      done <= next_done;
      dq_meta <= dq_in;
      dq_sync <= dq_meta;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_write_gate_high: assert property (!we_n |-> oe_n && !ce_n)
    else $error("write strobe low without output gate high");
  a_write_pulse_width: assert property ($fell(we_n) |-> !we_n [*2])
    else $error("write pulse shorter than glitch margin");
  a_addr_stable: assert property (!ce_n |-> $stable(addr))
    else $error("address moved during strobe");
  // an abort releases strobe and data together, so only the normal strobe rise is held
  a_data_held: assert property ($rose(we_n) && state == CY_HOLD |-> dq_oe && $stable(dq_out))
    else $error("write data released at strobe rise");
  a_abort_quiet: assert property (abort |=> ce_n && we_n && oe_n && !dq_oe)
    else $error("strobes active after abort");
endmodule

// file: hdl/fpc_flash_host.sv
// host controller that drives the parallel flash pins for id, protect and secured sector
// What this block does
// - high-voltage A9 reads maker or part code
// - high-voltage A9 with A1 reads group protection
// - host exits secured mode before main-array reads and programs, not raw writes
// - host keeps control pins inactive near lockout
module fpc_flash_host #(
  parameter int HV_SETTLE_CYC = fpc_pkg::HV_SETTLE_CYC,
  parameter int RESET_PULSE_CYC = fpc_pkg::RESET_PULSE_CYC,
  parameter int RESET_RECOVER_CYC = fpc_pkg::RESET_RECOVER_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // command request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input fpc_pkg::fpc_cmd_t cmd_code,
  input wire logic [fpc_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [fpc_pkg::DATA_W-1:0] cmd_data,
  // response and status
  output logic rsp_valid,
  output logic [fpc_pkg::DATA_W-1:0] rsp_data,
  output logic rsp_protected,
  output logic secured_mode,
  output logic temp_unprotect,
  // supply monitor
  input wire logic supply_lockout,
  // flash pins
  output logic [fpc_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [fpc_pkg::DATA_W-1:0] flash_dq_in,
  output logic [fpc_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_n,
  output logic flash_reset_hv,
  output logic flash_a9_hv
);
  localparam int TIMER_W = 8;
  if (HV_SETTLE_CYC < 1 || HV_SETTLE_CYC > 255 || RESET_PULSE_CYC < 8 ||
      RESET_PULSE_CYC > 255 || RESET_RECOVER_CYC < 1 || RESET_RECOVER_CYC > 255) begin : g_chk
    $error("fpc_flash_host: timer counts out of range");
  end

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_SETTLE = 6'h02, ST_ISSUE = 6'h04,
    ST_WAIT = 6'h08, ST_RST_LOW = 6'h10, ST_RST_RECOVER = 6'h20
  } fpc_state_t;

  typedef struct packed {
    logic wr;
    logic last;
    logic [fpc_pkg::ADDR_W-1:0] addr;
    logic [fpc_pkg::DATA_W-1:0] data;
  } fpc_step_t;

  // bus cycle list of each command
  function automatic fpc_step_t step_of(input fpc_pkg::fpc_cmd_t c, input logic [2:0] s,
      input logic [fpc_pkg::ADDR_W-1:0] a, input logic [fpc_pkg::DATA_W-1:0] d);
    fpc_step_t r;
    logic [fpc_pkg::ADDR_W-1:0] id_addr;
    r.wr = 1'b1;
    r.last = 1'b0;
    r.addr = fpc_pkg::UNLOCK_ADDR_1;
    r.data = fpc_pkg::UNLOCK_DATA_1;
    // A6, A1 and A0 low select the maker code
    id_addr = '0;
    id_addr[fpc_pkg::BIT_A9] = 1'b1;
    if (s == 3'h1) begin
      r.addr = fpc_pkg::UNLOCK_ADDR_2;
      r.data = fpc_pkg::UNLOCK_DATA_2;
    end else if (s == 3'h2) begin
      r.data = (c == fpc_pkg::CMD_ENTER_SECURED) ? fpc_pkg::SEQ_ENTER_SECURED :
               (c == fpc_pkg::CMD_PROGRAM) ? fpc_pkg::SEQ_PROGRAM : fpc_pkg::SEQ_AUTOSELECT;
    end
    case (c)
      fpc_pkg::CMD_ENTER_SECURED: r.last = (s == 3'h2);
      fpc_pkg::CMD_EXIT_SECURED: begin
        if (s == 3'h3) begin
          r.addr = '0;
          r.data = fpc_pkg::SEQ_EXIT_SECURED;
          r.last = 1'b1;
        end
      end
      fpc_pkg::CMD_PROGRAM: begin
        if (s == 3'h3) begin
          r.addr = a;
          r.data = d;
          r.last = 1'b1;
        end
      end
      fpc_pkg::CMD_WRITE_RAW: begin
        r.addr = a;
        r.data = d;
        r.last = 1'b1;
      end
      fpc_pkg::CMD_READ: begin
        r.wr = 1'b0;
        r.addr = a;
        r.last = 1'b1;
      end
      fpc_pkg::CMD_READ_MFR_ID, fpc_pkg::CMD_READ_DEV_ID: begin
        id_addr[fpc_pkg::BIT_A0] = (c == fpc_pkg::CMD_READ_DEV_ID);
        r.wr = 1'b0;
        r.addr = id_addr;
        r.last = 1'b1;
      end
      fpc_pkg::CMD_VERIFY_PROTECT: begin
        // A1 high, A0 and A6 low, group on the upper bits
        id_addr[fpc_pkg::BIT_A1] = 1'b1;
        id_addr[fpc_pkg::ADDR_W-1:fpc_pkg::GROUP_LSB] = a[fpc_pkg::ADDR_W-1:fpc_pkg::GROUP_LSB];
        r.wr = 1'b0;
        r.addr = id_addr;
        r.last = 1'b1;
      end
      default: r.last = 1'b1;
    endcase
    return r;
  endfunction

  fpc_state_t state, next_state;
  fpc_pkg::fpc_cmd_t cmd, next_cmd;
  logic [fpc_pkg::ADDR_W-1:0] addr, next_addr;
  logic [fpc_pkg::DATA_W-1:0] data, next_data, next_rsp_data, cyc_rdata;
  logic [2:0] step, next_step;
  logic [TIMER_W-1:0] timer, next_timer;
  logic exiting, next_exiting, next_secured_mode, next_temp_unprotect;
  logic a9_hv, next_a9_hv, reset_n, next_reset_n, next_rsp_valid, next_rsp_protected;
  logic lk_meta, lk_sync, cyc_start, cyc_done, needs_exit;
  fpc_step_t cur;

  assign cur = step_of(exiting ? fpc_pkg::CMD_EXIT_SECURED : cmd, step, addr, data);
  assign cmd_ready = (state == ST_IDLE) && !lk_sync && !reset;
  // main-array read or program while the secured sector is mapped goes out behind an exit; raw writes do not
  assign needs_exit = secured_mode &&
    (cmd_code == fpc_pkg::CMD_READ || cmd_code == fpc_pkg::CMD_PROGRAM) &&
    (cmd_addr[fpc_pkg::ADDR_W-1:fpc_pkg::FIRST_SECTOR_LSB] != '0);
  assign flash_reset_n = reset_n;
  assign flash_reset_hv = temp_unprotect;
  assign flash_a9_hv = a9_hv;

  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_addr = addr;
    next_data = data;
    next_step = step;
    next_timer = timer;
    next_exiting = exiting;
    next_secured_mode = secured_mode;
    next_temp_unprotect = temp_unprotect;
    next_a9_hv = a9_hv;
    next_reset_n = reset_n;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_rsp_protected = rsp_protected;
    cyc_start = 1'b0;
    case (state)
      ST_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          next_cmd = cmd_code;
          next_addr = cmd_addr;
          next_data = cmd_data;
          next_step = 3'h0;
          next_exiting = needs_exit;
          next_timer = TIMER_W'(HV_SETTLE_CYC - 1);
          next_state = ST_SETTLE;
          case (cmd_code)
            fpc_pkg::CMD_HW_RESET: begin
              next_reset_n = 1'b0;
              next_temp_unprotect = 1'b0;
              next_timer = TIMER_W'(RESET_PULSE_CYC - 1);
              next_state = ST_RST_LOW;
            end
            fpc_pkg::CMD_TEMP_UNPROTECT_ON: next_temp_unprotect = 1'b1;
            fpc_pkg::CMD_TEMP_UNPROTECT_OFF: next_temp_unprotect = 1'b0;
            fpc_pkg::CMD_READ_MFR_ID, fpc_pkg::CMD_READ_DEV_ID,
            fpc_pkg::CMD_VERIFY_PROTECT: next_a9_hv = 1'b1;
            default: next_state = ST_ISSUE;
          endcase
        end
      end
      ST_SETTLE: begin
        if (timer != '0) begin
          next_timer = timer - 1'b1;
        end else if (a9_hv) begin
          next_state = ST_ISSUE;
        end else begin
          next_rsp_valid = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_ISSUE: begin
        cyc_start = 1'b1;
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (cyc_done) begin
          next_state = ST_ISSUE;
          if (!cur.last) begin
            next_step = step + 3'h1;
          end else if (exiting) begin
            next_exiting = 1'b0;
            next_secured_mode = 1'b0;
            next_step = 3'h0;
          end else begin
            if (!cur.wr) begin
              next_rsp_data = cyc_rdata;
              next_rsp_protected = cyc_rdata[fpc_pkg::PROTECTED_BIT];
            end
            if (cmd == fpc_pkg::CMD_ENTER_SECURED) begin
              next_secured_mode = 1'b1;
            end else if (cmd == fpc_pkg::CMD_EXIT_SECURED) begin
              next_secured_mode = 1'b0;
            end
            next_a9_hv = 1'b0;
            next_rsp_valid = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      ST_RST_LOW: begin
        next_secured_mode = 1'b0;
        if (timer != '0) begin
          next_timer = timer - 1'b1;
        end else begin
          next_reset_n = 1'b1;
          next_timer = TIMER_W'(RESET_RECOVER_CYC - 1);
          next_state = ST_RST_RECOVER;
        end
      end
      ST_RST_RECOVER: begin
        if (timer != '0) begin
          next_timer = timer - 1'b1;
        end else begin
          next_rsp_valid = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // supply lockout drops everything and keeps the pins quiet
    if (lk_sync) begin
      next_state = ST_IDLE;
      next_exiting = 1'b0;
      next_secured_mode = 1'b0;
      next_temp_unprotect = 1'b0;
      next_a9_hv = 1'b0;
      next_reset_n = 1'b1;
      next_rsp_valid = 1'b0;
      cyc_start = 1'b0;
    end
  end

  // reset values keep every strobe high at power-up
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= ST_IDLE;
      cmd <= fpc_pkg::CMD_READ;
      addr <= '0;
      data <= '0;
      step <= 3'h0;
      timer <= '0;
      exiting <= 1'b0;
      secured_mode <= 1'b0;
      temp_unprotect <= 1'b0;
      a9_hv <= 1'b0;
      reset_n <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_protected <= 1'b0;
      lk_meta <= 1'b0;
      lk_sync <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      addr <= next_addr;
      data <= next_data;
      step <= next_step;
      timer <= next_timer;
      exiting <= next_exiting;
      secured_mode <= next_secured_mode;
      temp_unprotect <= next_temp_unprotect;
      a9_hv <= next_a9_hv;
      reset_n <= next_reset_n;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      rsp_protected <= next_rsp_protected;
      lk_meta <= supply_lockout;
      lk_sync <= lk_meta;
    end
  end

  fpc_bus_cycle u_cycle (
    .clock(clock),
    .reset(reset),
    .start(cyc_start),
    .abort(lk_sync),
    .in_write(cur.wr),
    .in_addr(cur.addr),
    .in_data(cur.data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .addr(flash_addr),
    .dq_in(flash_dq_in),
    .dq_out(flash_dq_out),
    .dq_oe(flash_dq_oe),
    .ce_n(flash_ce_n),
    .oe_n(flash_oe_n),
    .we_n(flash_we_n)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_lockout_quiet: assert property (lk_sync |=> flash_we_n && flash_ce_n)
    else $error("strobe active during supply lockout");
  a_id_read_pins: assert property (flash_a9_hv && !flash_oe_n |->
      !flash_ce_n && flash_we_n && !flash_addr[fpc_pkg::BIT_A6])
    else $error("bad pin levels during high-voltage id read");
  a_verify_addr: assert property (flash_a9_hv && !flash_oe_n &&
      cmd == fpc_pkg::CMD_VERIFY_PROTECT |->
      flash_addr[fpc_pkg::BIT_A1] && !flash_addr[fpc_pkg::BIT_A0])
    else $error("verify read without A1 high and A0 low");
  a_reset_clears_sec: assert property (!flash_reset_n |=> !secured_mode)
    else $error("secured mode kept through hardware reset");
  a_exit_first: assert property (!flash_ce_n &&
      flash_addr[fpc_pkg::ADDR_W-1:fpc_pkg::FIRST_SECTOR_LSB] != '0 |-> !secured_mode)
    else $error("main array touched while secured sector mapped");
  a_reset_pulse: assert property ($fell(flash_reset_n) |-> !flash_reset_n [*8])
    else $error("reset pulse too short");
  a_hv_settle: assert property ($rose(flash_a9_hv) |-> flash_oe_n [*8])
    else $error("read started before high voltage settled");
  c_program: cover property (rsp_valid && cmd == fpc_pkg::CMD_PROGRAM && !secured_mode);
  c_exit_prefix: cover property (exiting && cyc_done && cur.last);
  c_verify: cover property (rsp_valid && cmd == fpc_pkg::CMD_VERIFY_PROTECT && rsp_protected);
  c_lockout: cover property ($rose(lk_sync) && state != ST_IDLE);
endmodule

// file: verification/fpc_flash_model.sv
// behavioural parallel flash device that answers the host pins
module fpc_flash_model #(
  parameter logic [15:0] MFR_CODE = 16'h00A5, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h1234, // arbitrary value
  parameter logic LOCKED = 1'b0
) (
  // flash pins
  input wire logic [21:0] addr,
  input wire logic [15:0] din,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic reset_hv,
  input wire logic a9_hv,
  // supply monitor
  input wire logic lockout,
  output logic [15:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [logic [21:0]];
  logic [15:0] sec [0:127];
  logic [63:0] prot = 64'h2;
  logic [15:0] last = 16'h0000;
  logic [2:0] step = 3'h0;
  logic sec_mode = 1'b0;
  logic [15:0] rd;
  // time at which the current write pulse began; zero means it began at power-up
  realtime wr_start = 0.0;
  wire wr = !ce_n && !we_n && oe_n;
  wire in_sec = sec_mode && addr[21:15] == 7'h00;
  initial begin
    foreach (sec[i]) sec[i] = (LOCKED && i < 8) ? 16'h5A00 + 16'(i) : 16'hFFFF;
  end
  always @* begin
    if (a9_hv) begin
      case (addr[1:0])
        2'h0: rd = MFR_CODE;
        2'h1: rd = DEV_CODE;
        2'h2: rd = {15'h0000, prot[addr[21:16]]};
        default: rd = {8'h00, LOCKED, 7'h00};
      endcase
    end else if (in_sec) begin
      rd = sec[addr[6:0]];
    end else begin
      rd = mem.exists(addr) ? mem[addr] : 16'hFFFF;
    end
  end
  // released bus shows the inverse of the last driven word
  assign dq = (reset_n && !ce_n && !oe_n) ? rd : ~last;
  always @(posedge oe_n) last = dq;
  always @(posedge wr) wr_start = $realtime;
  always @(negedge reset_n or posedge lockout) begin
    step = 3'h0;
    sec_mode = 1'b0;
  end
  always @(negedge wr) begin
    if (reset_n && !lockout &&
        wr_start > 0.0 && $realtime - wr_start >= 5.0) begin
      if (step == 3'h3) begin
        if (in_sec) begin
          if (!LOCKED) sec[addr[6:0]] = din;
        end else if (!prot[addr[21:16]] || reset_hv) begin
          mem[addr] = din;
        end
        step = 3'h0;
      end else if (step == 3'h4) begin
        if (din == 16'h0000) sec_mode = 1'b0;
        step = 3'h0;
      end else if (addr == 22'h000555 && din == 16'h00AA) begin
        step = 3'h1;
      end else if (step == 3'h1 && addr == 22'h0002AA && din == 16'h0055) begin
        step = 3'h2;
      end else if (step == 3'h2 && din == 16'h0088) begin
        sec_mode = 1'b1;
        step = 3'h0;
      end else if (step == 3'h2 && din == 16'h00A0) begin
        step = 3'h3;
      end else begin
        step = (step == 3'h2 && din == 16'h0090) ? 3'h4 : 3'h0;
      end
    end
  end
endmodule

// file: verification/fpc_flash_host_tb.sv
// self-checking bench for the flash host controller against a device model
module fpc_flash_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MFR = 16'h00A5; // arbitrary value
  localparam logic [15:0] DEV = 16'h1234; // arbitrary value
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  fpc_pkg::fpc_cmd_t cmd_code = fpc_pkg::CMD_READ;
  logic [21:0] cmd_addr = 22'h000000;
  logic [15:0] cmd_data = 16'h0000;
  logic supply_lockout = 1'b0;
  logic cmd_ready, rsp_valid, rsp_protected, secured_mode, temp_unprotect;
  logic [15:0] rsp_data, flash_dq_in, flash_dq_out;
  logic [21:0] flash_addr;
  logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
  logic flash_reset_n, flash_reset_hv, flash_a9_hv;
  int fails = 0;
  int n_compared = 0;
  initial forever #12.5 clock = ~clock;
  fpc_flash_host #(.HV_SETTLE_CYC(8), .RESET_PULSE_CYC(8), .RESET_RECOVER_CYC(1))
    fpc_flash_host_inst (.clock, .reset, .cmd_valid, .cmd_ready, .cmd_code, .cmd_addr,
    .cmd_data, .rsp_valid, .rsp_data, .rsp_protected, .secured_mode, .temp_unprotect,
    .supply_lockout, .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe, .flash_ce_n,
    .flash_oe_n, .flash_we_n, .flash_reset_n, .flash_reset_hv, .flash_a9_hv);
  fpc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .LOCKED(1'b0)) fpc_flash_model_inst (
    .addr(flash_addr), .din(flash_dq_out), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
    .we_n(flash_we_n), .reset_n(flash_reset_n), .reset_hv(flash_reset_hv),
    .a9_hv(flash_a9_hv), .lockout(supply_lockout), .dq(flash_dq_in));
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1) begin
      @(negedge clock);
      n++;
      if (n > 2000) begin
        fails++;
        end_of_test();
      end
    end
  endtask
  task automatic cmd(input fpc_pkg::fpc_cmd_t c, input logic [21:0] a, input logic [15:0] d);
    @(negedge clock);
    wait_hi(cmd_ready);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_addr = a;
    cmd_data = d;
    @(negedge clock);
    cmd_valid = 1'b0;
    wait_hi(rsp_valid);
  endtask
  task automatic t_ids;
    cmd(fpc_pkg::CMD_READ_MFR_ID, 22'h000000, 16'h0000);
    chk(rsp_data, MFR);
    cmd(fpc_pkg::CMD_READ_DEV_ID, 22'h000000, 16'h0000);
    chk(rsp_data, DEV);
    cmd(fpc_pkg::CMD_VERIFY_PROTECT, 22'h010000, 16'h0000);
    chk(rsp_data, 16'h0001);
    cmd(fpc_pkg::CMD_VERIFY_PROTECT, 22'h020000, 16'h0000);
    chk({15'h0000, rsp_protected}, 16'h0000);
    $display("test ids done");
  endtask
  task automatic t_protect;
    cmd(fpc_pkg::CMD_PROGRAM, 22'h020004, 16'h1111);
    cmd(fpc_pkg::CMD_READ, 22'h020004, 16'h0000);
    chk(rsp_data, 16'h1111);
    cmd(fpc_pkg::CMD_WRITE_RAW, 22'h020008, 16'h7777);
    cmd(fpc_pkg::CMD_READ, 22'h020008, 16'h0000);
    chk(rsp_data, 16'hFFFF);
    cmd(fpc_pkg::CMD_TEMP_UNPROTECT_ON, 22'h000000, 16'h0000);
    chk({15'h0000, temp_unprotect}, 16'h0001);
    cmd(fpc_pkg::CMD_PROGRAM, 22'h010004, 16'h3333);
    cmd(fpc_pkg::CMD_TEMP_UNPROTECT_OFF, 22'h000000, 16'h0000);
    cmd(fpc_pkg::CMD_READ, 22'h010004, 16'h0000);
    chk(rsp_data, 16'h3333);
    cmd(fpc_pkg::CMD_PROGRAM, 22'h010008, 16'h4444);
    cmd(fpc_pkg::CMD_READ, 22'h010008, 16'h0000);
    chk(rsp_data, 16'hFFFF);
    $display("test protect done");
  endtask
  task automatic t_secured;
    cmd(fpc_pkg::CMD_ENTER_SECURED, 22'h000000, 16'h0000);
    chk({15'h0000, secured_mode}, 16'h0001);
    cmd(fpc_pkg::CMD_PROGRAM, 22'h000005, 16'h5555);
    cmd(fpc_pkg::CMD_READ, 22'h000005, 16'h0000);
    chk(rsp_data, 16'h5555);
    cmd(fpc_pkg::CMD_READ, 22'h020004, 16'h0000);
    chk(rsp_data, 16'h1111);
    chk({15'h0000, secured_mode}, 16'h0000);
    cmd(fpc_pkg::CMD_READ, 22'h000005, 16'h0000);
    chk(rsp_data, 16'hFFFF);
    cmd(fpc_pkg::CMD_ENTER_SECURED, 22'h000000, 16'h0000);
    cmd(fpc_pkg::CMD_EXIT_SECURED, 22'h000000, 16'h0000);
    chk({15'h0000, secured_mode}, 16'h0000);
    cmd(fpc_pkg::CMD_READ, 22'h000005, 16'h0000);
    chk(rsp_data, 16'hFFFF);
    cmd(fpc_pkg::CMD_ENTER_SECURED, 22'h000000, 16'h0000);
    cmd(fpc_pkg::CMD_HW_RESET, 22'h000000, 16'h0000);
    chk({15'h0000, secured_mode}, 16'h0000);
    cmd(fpc_pkg::CMD_READ, 22'h000005, 16'h0000);
    chk(rsp_data, 16'hFFFF);
    $display("test secured done");
  endtask
  task automatic t_lockout;
    int n;
    n = 0;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_code = fpc_pkg::CMD_PROGRAM;
    cmd_addr = 22'h020010;
    cmd_data = 16'h6666;
    @(negedge clock);
    cmd_valid = 1'b0;
    repeat (8) @(negedge clock);
    supply_lockout = 1'b1;
    repeat (20) begin
      @(negedge clock);
      if (rsp_valid === 1'b1) n++;
    end
    chk({15'h0000, cmd_ready}, 16'h0000);
    chk(n[15:0], 16'h0000);
    supply_lockout = 1'b0;
    cmd(fpc_pkg::CMD_READ, 22'h020010, 16'h0000);
    chk(rsp_data, 16'hFFFF);
    $display("test lockout done");
  endtask
  initial begin
    repeat (2) @(negedge clock);
    reset = 1'b0;
    t_ids();
    t_protect();
    t_secured();
    t_lockout();
    end_of_test();
  end
endmodule
